/* File: gas_transmitter_regs.sv */
// Register bank of the gas transmitter field-bus slave
`timescale 1ns/10ps
`default_nettype none
`include "gas_reg_defines.svh"

module gas_transmitter_regs
  import gas_reg_pkg::*;
#(
  parameter int unsigned STEP_CYC  = `DELAY_STEP_MS * (`NS_PER_MS / `CLK_PERIOD_NS),
  parameter int unsigned APPLY_CYC = `APPLY_WAIT_MS * (`NS_PER_MS / `CLK_PERIOD_NS)
) (
  input  wire logic        core_clk,          // 200 MHz clock
  input  wire logic        rst_b,             // Async reset, active low
  input  wire logic        reg_wr_en,         // Register write strobe
  input  wire logic        reg_rd_en,         // Register read strobe
  input  wire logic [7:0]  reg_addr,          // Register number
  input  wire logic [15:0] reg_wdata,         // Write value
  output logic      [15:0] reg_rdata_ff,      // Read value
  output logic             reg_ack_ff,        // Access accepted
  output logic             reg_err_ff,        // Access refused
  input  wire logic        req_rcvd,          // Request for this station seen
  output logic             reply_go_ff,       // Reply may start now
  input  wire logic [7:0]  fault_src,         // Fault conditions, bit per fault
  input  wire logic [15:0] supply_mv,         // Measured supply in mV
  input  wire logic        warmup_active,     // Sensor warming up
  input  wire logic        meas_stable,       // Measurement stable
  input  wire logic        init_done,         // Initialization over
  output logic      [7:0]  active_station_ff, // Station address in use
  output logic      [15:0] line_div_ff,       // Clocks per bit at line rate
  output logic             data8_ff,          // Eight data bits
  output logic             rtu_mode_ff,       // RTU framing
  output logic      [1:0]  parity_sel_ff      // Parity code in use
);

  reply_timer_if tif ();

  logic [7:0]  station_ff;
  logic [7:0]  delay_ff;
  logic [1:0]  rate_ff;
  framing_t    framing_ff;
  logic [7:0]  act_delay_ff;
  logic [7:0]  fault_ff;
  logic [15:0] supply_ff;
  logic [2:0]  board_ff;
  logic        busy_ff;
  logic        wr_ok;
  logic        wr_take;
  logic        rd_ok;
  logic [15:0] rd_val;
  logic        start_delay_ff;
  logic        start_apply_ff;

  // Bit time in core clocks for a line rate code
  function automatic logic [15:0] rate_div(input logic [1:0] code);
    int unsigned baud;
    baud = `BAUD_CODE0;
    case (code)
      2'h0: baud = `BAUD_CODE0;
      2'h1: baud = `BAUD_CODE1;
      2'h2: baud = `BAUD_CODE2;
      2'h3: baud = `BAUD_CODE3;
      default: baud = `BAUD_CODE1;
    endcase
    return 16'((`CLK_HZ + baud / 2) / baud);
  endfunction

  // Address map membership for reads
  function automatic logic addr_mapped(input logic [7:0] a);
    return a <= `OFS_BOARD;
  endfunction

  // Divider for the reset rate code 1; a plain constant keeps
  // the asynchronous reset branch free of any logic
  localparam logic [15:0] RST_DIV = 16'((`CLK_HZ + `BAUD_CODE1 / 2) / `BAUD_CODE1);

  // Write legality: refuse values the settings cannot hold
  always_comb begin
    wr_ok = 1'b0;
    case (reg_addr)
      `OFS_STATION: wr_ok = (reg_wdata >= 16'(`STATION_MIN)) && (reg_wdata <= 16'(`STATION_MAX));
      `OFS_REPLY_DELAY: wr_ok = reg_wdata[15:8] == 8'h0;
      `OFS_LINE_RATE: wr_ok = reg_wdata <= `LINE_RATE_MAX;
      `OFS_FRAMING: wr_ok = (reg_wdata[15:4] == 12'h0)
                            && (reg_wdata[`FRM_PAR_HI:`FRM_PAR_LO] != `PAR_UNASSIGNED);
      default: wr_ok = 1'b0;
    endcase
  end

  // Reads refused past the last mapped register
  assign rd_ok = addr_mapped(reg_addr);
  // Write that is stored at this edge
  assign wr_take = reg_wr_en && wr_ok;

  // Read multiplexer; reserved range reads zero
  always_comb begin
    rd_val = 16'h0;
    case (reg_addr)
      `OFS_STATION:     rd_val = {8'h0, station_ff};
      `OFS_REPLY_DELAY: rd_val = {8'h0, delay_ff};
      `OFS_LINE_RATE:   rd_val = {14'h0, rate_ff};
      `OFS_FRAMING:     rd_val = {12'h0, framing_ff};
      `OFS_FAULT:       rd_val = {8'h0, fault_ff};
      `OFS_SUPPLY:      rd_val = supply_ff;
      `OFS_BOARD:       rd_val = {13'h0, board_ff};
      default:          rd_val = 16'h0;
    endcase
  end

  // Access answer, one cycle after the strobe; write wins if both are raised
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_ff <= 16'h0;
      reg_ack_ff   <= 1'b0;
      reg_err_ff   <= 1'b0;
    end else begin
      reg_ack_ff <= 1'b0;
      reg_err_ff <= 1'b0;
      if (reg_wr_en) begin
        reg_ack_ff <= wr_ok;
        reg_err_ff <= !wr_ok;
      end else if (reg_rd_en) begin
        reg_ack_ff   <= rd_ok;
        reg_err_ff   <= !rd_ok;
        reg_rdata_ff <= rd_ok ? rd_val : 16'h0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      station_ff <= `RST_STATION;
    end else if (wr_take && (reg_addr == `OFS_STATION)) begin
      station_ff <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      delay_ff <= `RST_REPLY_DELAY;
    end else if (wr_take && (reg_addr == `OFS_REPLY_DELAY)) begin
      delay_ff <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rate_ff <= `RST_LINE_RATE;
    end else if (wr_take && (reg_addr == `OFS_LINE_RATE)) begin
      rate_ff <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      framing_ff <= `RST_FRAMING;
    end else if (wr_take && (reg_addr == `OFS_FRAMING)) begin
      framing_ff <= reg_wdata[3:0];
    end
  end

  // Settle wait restarts on every stored address, delay or rate write;
  // framing is left out because it applies at once
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      start_apply_ff <= 1'b0;
    end else begin
      start_apply_ff <= wr_take && ((reg_addr == `OFS_STATION) || (reg_addr == `OFS_REPLY_DELAY)
                                    || (reg_addr == `OFS_LINE_RATE));
    end
  end

  // Settings in use; address, delay and rate switch after the settle wait
  // so the reply to the writing request still goes out on the old settings
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      active_station_ff <= `RST_STATION;
      act_delay_ff      <= `RST_REPLY_DELAY;
      line_div_ff       <= RST_DIV;
    end else if (tif.apply_done) begin
      active_station_ff <= station_ff;
      act_delay_ff      <= delay_ff;
      line_div_ff       <= rate_div(rate_ff);
    end
  end

  // Framing takes effect at once
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      data8_ff      <= 1'b1;
      rtu_mode_ff   <= 1'b1;
      parity_sel_ff <= `PAR_NONE;
    end else begin
      data8_ff      <= framing_ff.data8;
      rtu_mode_ff   <= framing_ff.rtu;
      parity_sel_ff <= framing_ff.parity;
    end
  end

  // Fault levels captured each cycle; live, not latched, so no set/clear race
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_ff <= 8'h0;
    end else begin
      fault_ff[4:0] <= fault_src[4:0];
      fault_ff[5]   <= fault_src[5];
      fault_ff[6]   <= fault_src[6];
      fault_ff[7]   <= fault_src[7];
    end
  end

  // Supply reading, passed through one register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      supply_ff <= 16'h0;
    end else begin
      supply_ff <= supply_mv;
    end
  end

  // Board status levels, one cycle behind their sources
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      board_ff <= 3'h0;
    end else begin
      board_ff[0] <= warmup_active;
      board_ff[1] <= meas_stable;
      board_ff[2] <= init_done;
    end
  end

  // Reply scheduling; requests during a running delay are dropped
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_ff        <= 1'b0;
      start_delay_ff <= 1'b0;
      reply_go_ff    <= 1'b0;
    end else begin
      start_delay_ff <= 1'b0;
      reply_go_ff    <= tif.delay_done;
      if (req_rcvd && !busy_ff) begin
        busy_ff        <= 1'b1;
        start_delay_ff <= 1'b1;
      end else if (tif.delay_done) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // Timer handshake, every signal straight from a flop
  assign tif.start_delay = start_delay_ff;
  assign tif.delay_steps = act_delay_ff;
  assign tif.start_apply = start_apply_ff;

  // Long counters kept in their own module
  reply_timer #(
    .STEP_CYC  (STEP_CYC),
    .APPLY_CYC (APPLY_CYC)
  ) u_timer (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tif      (tif)
  );

endmodule
`default_nettype wire

/* File: gas_reg_defines.svh */
// Offsets, field positions, reset values and timing figures of the register bank
`ifndef GAS_REG_DEFINES_SVH
`define GAS_REG_DEFINES_SVH

// Register offsets
`define OFS_STATION      8'h00
`define OFS_REPLY_DELAY  8'h01
`define OFS_LINE_RATE    8'h02
`define OFS_FRAMING      8'h03
`define OFS_FAULT        8'h04
`define OFS_SUPPLY       8'h05
`define OFS_RSVD_LO      8'h06
`define OFS_RSVD_HI      8'h20
`define OFS_BOARD        8'h21

// Reset values
`define RST_STATION      8'h01
`define RST_REPLY_DELAY  8'h0a
`define RST_LINE_RATE    2'h1
`define RST_FRAMING      4'hf

// Legal ranges
`define STATION_MIN      8'h01
`define STATION_MAX      8'hf7
`define LINE_RATE_MAX    16'h0003

// Framing field positions
`define FRM_DATA8_BIT    0
`define FRM_RTU_BIT      1
`define FRM_PAR_LO       2
`define FRM_PAR_HI       3
`define PAR_UNASSIGNED   2'h0
`define PAR_EVEN         2'h1
`define PAR_ODD          2'h2
`define PAR_NONE         2'h3

// Fault word and board status widths
`define FAULT_BITS       8
`define BOARD_BITS       3

// Line rates in baud
`define BAUD_CODE0       4800
`define BAUD_CODE1       9600
`define BAUD_CODE2       19200
`define BAUD_CODE3       38400

// Timing: clock period in ns, clock in Hz, delay step and settle wait in ms
`define CLK_PERIOD_NS    5
`define CLK_HZ           200000000
`define DELAY_STEP_MS    10
`define APPLY_WAIT_MS    200
`define NS_PER_MS        1000000

`endif

/* File: gas_reg_pkg.sv */
// Types shared by the register bank and its reply timer
package gas_reg_pkg;

  typedef enum logic {
    DLY_IDLE,
    DLY_RUN
  } delay_state_t;

  typedef struct packed {
    logic [1:0] parity;
    logic       rtu;
    logic       data8;
  } framing_t;

endpackage

/* File: reply_timer_if.sv */
// Handshake between the register bank and its reply timer
`timescale 1ns/10ps
`default_nettype none
interface reply_timer_if;
  logic       start_delay;   // Pulse: begin reply delay
  logic [7:0] delay_steps;   // Delay in 10 ms steps
  logic       delay_done;    // Pulse: reply delay over
  logic       start_apply;   // Pulse: (re)start settle wait
  logic       apply_done;    // Pulse: settle wait over

  modport ctl (output start_delay, output delay_steps, output start_apply,
               input delay_done, input apply_done);
  modport tmr (input start_delay, input delay_steps, input start_apply,
               output delay_done, output apply_done);
endinterface
`default_nettype wire

/* File: reply_timer.sv */
// Reply delay and settle wait timers
`timescale 1ns/10ps
`default_nettype none
`include "gas_reg_defines.svh"
module reply_timer
  import gas_reg_pkg::*;
#(
  parameter int unsigned STEP_CYC  = 2000000,
  parameter int unsigned APPLY_CYC = 40000000
) (
  input  wire logic   core_clk,  // 200 MHz clock
  input  wire logic   rst_b,     // Async reset, active low
  reply_timer_if.tmr  tif        // Timer handshake
);

  delay_state_t st_ff;
  logic [20:0]  pre_ff;
  logic [7:0]   steps_ff;
  logic [25:0]  apply_ff;
  logic         apply_run_ff;

  // Delay sequencer; the prescaler restarts with each request so steps are whole
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff          <= DLY_IDLE;
      pre_ff         <= 21'h0;
      steps_ff       <= 8'h0;
      tif.delay_done <= 1'b0;
    end else begin
      tif.delay_done <= 1'b0;
      case (st_ff)
        DLY_IDLE: begin
          if (tif.start_delay) begin
            if (tif.delay_steps == 8'h0) begin
              tif.delay_done <= 1'b1;
            end else begin
              st_ff    <= DLY_RUN;
              steps_ff <= tif.delay_steps;
              pre_ff   <= 21'(STEP_CYC - 1);
            end
          end
        end
        DLY_RUN: begin
          if (pre_ff != 21'h0) begin
            pre_ff <= pre_ff - 21'h1;
          end else if (steps_ff == 8'h1) begin
            st_ff          <= DLY_IDLE;
            tif.delay_done <= 1'b1;
          end else begin
            steps_ff <= steps_ff - 8'h1;
            pre_ff   <= 21'(STEP_CYC - 1);
          end
        end
        default: begin
          st_ff <= DLY_IDLE;
        end
      endcase
    end
  end

  // Settle wait; a new write restarts it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      apply_ff       <= 26'h0;
      apply_run_ff   <= 1'b0;
      tif.apply_done <= 1'b0;
    end else begin
      tif.apply_done <= 1'b0;
      if (tif.start_apply) begin
        apply_ff     <= 26'(APPLY_CYC - 1);
        apply_run_ff <= 1'b1;
      end else if (apply_run_ff) begin
        if (apply_ff == 26'h0) begin
          apply_run_ff   <= 1'b0;
          tif.apply_done <= 1'b1;
        end else begin
          apply_ff <= apply_ff - 26'h1;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: gas_transmitter_regs_assertions.sv */
// Port-level checks of the register bank
`timescale 1ns/10ps
`default_nettype none
module gas_regs_checker (
  input wire logic        core_clk,      // Clock
  input wire logic        rst_b,         // Reset, active low
  input wire logic        reg_wr_en,     // Write strobe
  input wire logic        reg_rd_en,     // Read strobe
  input wire logic [7:0]  reg_addr,      // Register number
  input wire logic [15:0] reg_wdata,     // Write value
  input wire logic [15:0] reg_rdata_ff,  // Read value
  input wire logic        reg_ack_ff,    // Accepted
  input wire logic        reg_err_ff,    // Refused
  input wire logic        reply_go_ff,   // Reply release
  input wire logic [7:0]  fault_src,     // Fault levels
  input wire logic        warmup_active, // Warm-up
  input wire logic        meas_stable,   // Stable
  input wire logic        init_done,     // Init over
  input wire logic        data8_ff,      // Eight bits
  input wire logic        rtu_mode_ff,   // RTU framing
  input wire logic [1:0]  parity_sel_ff  // Parity code
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Refusals answered on the next edge
  AST_BAD_STATION: assert property (reg_wr_en && reg_addr == 8'h00 &&
    (reg_wdata == 16'h0000 || reg_wdata > 16'h00f7) |=> reg_err_ff) else $error("bad station accepted");
  AST_RATE_BAD: assert property (reg_wr_en && reg_addr == 8'h02 && reg_wdata > 16'h0003
    |=> reg_err_ff) else $error("bad line rate accepted");
  AST_RO_WRITE: assert property (reg_wr_en && reg_addr >= 8'h04 && reg_addr <= 8'h21
    |=> reg_err_ff && !reg_ack_ff) else $error("read-only write accepted");
  AST_RD_RANGE: assert property (reg_rd_en && !reg_wr_en && reg_addr > 8'h21
    |=> reg_err_ff && reg_rdata_ff == 16'h0000) else $error("unmapped read accepted");

  // Framing outputs follow a legal write two edges on
  AST_FRM_LOW: assert property (reg_wr_en && reg_addr == 8'h03 && reg_wdata[15:4] == 12'h000 &&
    reg_wdata[3:2] != 2'h0 |-> ##2 {rtu_mode_ff, data8_ff} == $past(reg_wdata[1:0], 2))
    else $error("data length or mode wrong");
  AST_FRM_PAR: assert property (reg_wr_en && reg_addr == 8'h03 && reg_wdata[15:4] == 12'h000 &&
    reg_wdata[3:2] != 2'h0 |-> ##2 parity_sel_ff == $past(reg_wdata[3:2], 2)) else $error("parity wrong");

  // Live levels; stable inputs avoid the one-cycle sampling lag
  AST_FAULT_RD: assert property (reg_rd_en && !reg_wr_en && reg_addr == 8'h04 &&
    $stable(fault_src) && $past(rst_b) |=> reg_rdata_ff == {8'h00, $past(fault_src)})
    else $error("fault word wrong");
  AST_BOARD_RD: assert property (reg_rd_en && !reg_wr_en && reg_addr == 8'h21 &&
    $stable({init_done, meas_stable, warmup_active}) && $past(rst_b)
    |=> reg_rdata_ff == {13'h0000, $past({init_done, meas_stable, warmup_active})})
    else $error("board status wrong");
  AST_GO_PULSE: assert property (reply_go_ff |=> !reply_go_ff) else $error("reply release too long");
endmodule
bind gas_transmitter_regs gas_regs_checker u_gas_regs_checker (.core_clk, .rst_b, .reg_wr_en, .reg_rd_en,
  .reg_addr, .reg_wdata, .reg_rdata_ff, .reg_ack_ff, .reg_err_ff, .reply_go_ff, .fault_src, .warmup_active,
  .meas_stable, .init_done, .data8_ff, .rtu_mode_ff, .parity_sel_ff);
`default_nettype wire

/* File: bus_master_model.sv */
// Field-bus master stand-in: raises requests, times replies
`timescale 1ns/10ps
`default_nettype none
module bus_master_model (
  input  wire logic        core_clk,    // Clock
  input  wire logic        rst_b,       // Reset, active low
  input  wire logic        send,        // Bench asks for a request
  input  wire logic        reply_go_ff, // Reply release
  output logic             req_rcvd,    // Request pulse
  output logic             busy,        // Awaiting reply
  output logic      [15:0] wait_cyc     // Request to reply
);
  // times the delay
  // Repeat requests still go out, so the bank must ignore them
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_rcvd <= 1'b0;
      busy     <= 1'b0;
      wait_cyc <= 16'h0000;
    end else begin
      req_rcvd <= send;
      if (send && !busy) begin
        busy     <= 1'b1;
        wait_cyc <= 16'h0000;
      end else if (busy) begin
        wait_cyc <= wait_cyc + 16'h0001;
        if (reply_go_ff) begin
          busy <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: gas_transmitter_regs_bench.sv */
// Self-checking bench for the register bank
`timescale 1ns/10ps
`default_nettype none
`include "gas_reg_defines.svh"
module gas_transmitter_regs_bench;
  localparam int unsigned STEP  = 4;
  localparam int unsigned APPLY = 8;
  logic        core_clk;
  logic        rst_b;
  logic        reg_wr_en;
  logic        reg_rd_en;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata_ff;
  logic        reg_ack_ff;
  logic        reg_err_ff;
  logic        req_rcvd;
  logic        reply_go_ff;
  logic [7:0]  fault_src;
  logic [15:0] supply_mv;
  logic [2:0]  stat;
  logic [7:0]  active_station_ff;
  logic [15:0] line_div_ff;
  logic        data8_ff;
  logic        rtu_mode_ff;
  logic [1:0]  parity_sel_ff;
  logic        send;
  logic        busy;
  logic [15:0] wait_cyc;
  logic [3:0]  f;
  int          mismatches;
  int          samples_checked;
  // Rounded core clocks per bit at 4800, 9600, 19200 and 38400 baud
  logic [15:0] div_exp [4] = '{16'ha2c3, 16'h5161, 16'h28b1, 16'h1458};

  gas_transmitter_regs #(.STEP_CYC(STEP), .APPLY_CYC(APPLY)) u_gas_transmitter_regs (.core_clk, .rst_b,
    .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata_ff, .reg_ack_ff, .reg_err_ff, .req_rcvd,
    .reply_go_ff, .fault_src, .supply_mv, .warmup_active(stat[0]), .meas_stable(stat[1]),
    .init_done(stat[2]), .active_station_ff, .line_div_ff, .data8_ff, .rtu_mode_ff, .parity_sel_ff);
  bus_master_model u_bus_master_model (.core_clk, .rst_b, .send, .reply_go_ff, .req_rcvd, .busy, .wait_cyc);

  // Free-running 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One access, a quiet cycle after so strobes never toggle twice in a step
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d, input logic e);
    reg_wr_en = w;
    reg_rd_en = !w;
    reg_addr  = a;
    reg_wdata = d;
    tick();
    chk({14'h0000, reg_ack_ff, reg_err_ff}, {14'h0000, !e, e});
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    tick();
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    acc(1'b0, a, 16'h0000, 1'b0);
    chk(reg_rdata_ff, x);
  endtask

  task automatic settle();
    repeat (APPLY + 4) tick();
  endtask

  // Request, optionally a second one mid-delay, then time the release
  task automatic reply(input int n, input logic dbl);
    int k;
    send = 1'b1;
    tick();
    send = 1'b0;
    if (dbl) begin
      repeat (2) tick();
      send = 1'b1;
      tick();
      send = 1'b0;
    end
    k = 0;
    while (busy && k < 300) begin
      tick();
      k++;
    end
    if (busy) begin
      mismatches++;
      print_verdict();
    end
    chk(wait_cyc, 16'(4 + n * STEP));
    repeat (12) begin
      tick();
      chk({15'h0000, reply_go_ff}, 16'h0000);
    end
  endtask

  initial begin
    rst_b = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    fault_src = 8'h00;
    supply_mv = 16'h0000;
    stat = 3'h0;
    send = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    repeat (12) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    rd(8'h00, 16'h0001);
    rd(8'h01, 16'h000a);
    rd(8'h02, 16'h0001);
    rd(8'h03, 16'h000f);
    chk(line_div_ff, div_exp[1]);
    chk({12'h000, parity_sel_ff, rtu_mode_ff, data8_ff}, 16'h000f);
    reply(10, 1'b0);
    wr_station: begin
      acc(1'b1, 8'h00, 16'h0000, 1'b1);
      acc(1'b1, 8'h00, 16'h00f8, 1'b1);
      acc(1'b1, 8'h00, 16'h00f7, 1'b0);
      rd(8'h00, 16'h00f7);
      chk({8'h00, active_station_ff}, 16'h0001);
      settle();
      chk({8'h00, active_station_ff}, 16'h00f7);
    end
    // Every line rate code, then one past the end
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, 8'h02, 16'(c), 1'b0);
      settle();
      chk(line_div_ff, div_exp[c]);
    end
    acc(1'b1, 8'h02, 16'h0004, 1'b1);
    // Every framing value; parity code 0 must be refused
    for (int v = 0; v < 16; v++) begin
      f = 4'(v);
      acc(1'b1, 8'h03, {12'h000, f}, f[3:2] == 2'h0);
      if (f[3:2] != 2'h0) begin
        chk({12'h000, parity_sel_ff, rtu_mode_ff, data8_ff}, {12'h000, f});
        rd(8'h03, {12'h000, f});
      end
    end
    acc(1'b1, 8'h03, 16'h001f, 1'b1);
    acc(1'b1, 8'h01, 16'h0100, 1'b1);
    acc(1'b1, 8'h01, 16'h0000, 1'b0);
    settle();
    reply(0, 1'b0);
    acc(1'b1, 8'h01, 16'h0002, 1'b0);
    settle();
    reply(2, 1'b1);
    fault_src = 8'ha5;
    supply_mv = 16'h1234;
    for (int s = 0; s < 8; s++) begin
      stat = 3'(s);
      repeat (2) tick();
      rd(8'h21, {13'h0000, stat});
    end
    rd(8'h04, 16'h00a5);
    fault_src = 8'h5a;
    repeat (2) tick();
    rd(8'h04, 16'h005a);
    rd(8'h05, 16'h1234);
    rd(8'h06, 16'h0000);
    rd(8'h20, 16'h0000);
    acc(1'b0, 8'h22, 16'h0000, 1'b1);
    chk(reg_rdata_ff, 16'h0000);
    acc(1'b1, 8'h04, 16'h0000, 1'b1);
    acc(1'b1, 8'h21, 16'h0007, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
